// ### src/kme_pkg.sv
// constants, state codes and register map of the keyboard matrix encoder
// assumes one 200 MHz clock; every other rate comes from enable pulses
package kme_pkg;

   // ----------------------------------------------------------------
   // matrix geometry
   // ----------------------------------------------------------------
   localparam int KME_ROWS   = 9;
   localparam int KME_COLS   = 10;
   localparam int KME_KEYS   = 90;
   localparam int KME_WORD_W = 10;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int KME_CLK_NS   = 5;      // ref_clk period
   localparam int KME_HALF_NS  = 10000;  // half scan cycle, 50 kHz scan clock
   localparam int KME_HALF_CYC = KME_HALF_NS / KME_CLK_NS;
   localparam logic [16:0] KME_DET_EXTRA = 17'h00002; // extra cycles after detect
   localparam logic [15:0] KME_DELAY_RST = 16'h0008;  // delay interval, scan cycles

   // ----------------------------------------------------------------
   // register map and fields
   // ----------------------------------------------------------------
   localparam logic [3:0] KME_OFF_CTRL = 4'h0; // [15:0] delay interval
   localparam logic [3:0] KME_OFF_STAT = 4'h4; // sticky events, write 1 clears
   localparam logic [3:0] KME_OFF_MASK = 4'h8; // interrupt enables
   localparam logic [3:0] KME_OFF_WORD = 4'hc; // word, position, lock flag
   localparam int KME_EV_DET  = 0;
   localparam int KME_EV_REL  = 1;
   localparam int KME_EV_W    = 2;
   localparam int KME_WD_POS  = 16;
   localparam int KME_WD_LOCK = 24;
   localparam logic [1:0] KME_MASK_RST = 2'h0;

   // ----------------------------------------------------------------
   // scan control states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      KME_SCAN = 3'b001,
      KME_HOLD = 3'b010,
      KME_LOCK = 3'b100
   } kme_state_e;

endpackage

// ### src/kme_encoder.sv
// keyboard matrix encoder: scan, key memory, code lookup, register port
// assumes switch closure reads high on the selected column during evaluate
//
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/100ps

module kme_encoder #(
   parameter int HALF_CYC = kme_pkg::KME_HALF_CYC,
   parameter int DELAY_W  = 16
) (
   // clock and reset
   input  wire logic                              ref_clk,
   input  wire logic                              rst,
   // key matrix
   input  wire logic [kme_pkg::KME_COLS-1:0]      column_sense_inputs,
   output logic      [kme_pkg::KME_ROWS-1:0]      row_drive_outputs,
   output logic                                   precharge_active,
   output logic                                   delay_node,
   // mode pins
   input  wire logic                              lockout_select,
   input  wire logic                              mode_select_low,
   input  wire logic                              mode_select_high,
   // encoded output
   output logic      [kme_pkg::KME_WORD_W-1:0]    encoded_word_outputs,
   output logic                                   data_ready,
   // register port
   input  wire logic [3:0]                        reg_addr,
   input  wire logic [31:0]                       reg_wdata,
   input  wire logic                              reg_wr,
   input  wire logic                              reg_rd,
   output logic      [31:0]                       reg_rdata,
   output logic                                   irq
);
   import kme_pkg::*;

   // ----------------------------------------------------------------
   // parameter checks
   // ----------------------------------------------------------------
   // the column synchroniser needs two edges inside one evaluate half,
   // and the half-cycle divider is only 16 bits wide
   if (HALF_CYC < 3 || HALF_CYC > 65536) begin : g_bad_half
      $error("HALF_CYC must lie in 3 to 65536");
   end
   if (DELAY_W != 16) begin : g_bad_dw
      $error("DELAY_W must be 16");
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // linear key position from row and column
   function automatic logic [6:0] pos_of(input logic [3:0] r, input logic [3:0] c);
      return 7'({3'h0, r}) * 7'h0a + 7'({3'h0, c});
   endfunction

   // code table: mode index in the top bits keeps all 360 codes distinct
   function automatic logic [9:0] rom_code(input logic [1:0] md, input logic [6:0] p);
      return {md, 1'b0, p};
   endfunction

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [15:0]          div_cnt_ff;
   logic                 tick;
   logic                 ev;
   logic                 phase_ff;
   logic [9:0]           col_s1_ff;
   logic [9:0]           col_s2_ff;
   logic [2:0]           pin_s1_ff;
   logic [2:0]           pin_s2_ff;
   logic                 lo_sel;
   logic [1:0]           mode_idx;
   logic [3:0]           row_ff;
   logic [3:0]           col_ff;
   logic [6:0]           pos;
   logic                 sensed;
   logic                 stored;
   logic                 hit_new;
   logic                 hit_rel;
   logic                 det;
   logic                 rel;
   logic                 adv;
   kme_state_e           state_ff;
   logic [16:0]          hold_cnt_ff;
   logic                 locked_ff;
   logic                 key_mem_ff [KME_KEYS];
   logic [9:0]           word_ff;
   logic [1:0]           dr_left_ff;
   logic                 dr_ff;
   logic [8:0]           row_drv_ff;
   logic                 pre_ff;
   logic [15:0]          delay_ff;
   logic [1:0]           stat_ff;
   logic [1:0]           mask_ff;
   logic [1:0]           nxt_stat;
   logic [31:0]          rdata_ff;

   // ----------------------------------------------------------------
   // scan clock: half-cycle enable and phase
   // ----------------------------------------------------------------
   // divider gives one pulse per half scan cycle
   always_ff @(posedge ref_clk) begin
      if (rst || tick) begin
         div_cnt_ff <= 16'h0000;
      end else begin
         div_cnt_ff <= div_cnt_ff + 16'h0001;
      end
   end
   assign tick = (div_cnt_ff == 16'(HALF_CYC - 1));
   // ev ends an evaluate half; the scan and hold counters only move here
   assign ev   = tick && phase_ff;

   // phase low = precharge half, high = evaluate half
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         phase_ff <= 1'b0;
      end else if (tick) begin
         phase_ff <= !phase_ff;
      end
   end

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   // switches and straps are asynchronous to ref_clk
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         col_s1_ff <= 10'h000;
         col_s2_ff <= 10'h000;
         pin_s1_ff <= 3'h0;
         pin_s2_ff <= 3'h0;
      end else begin
         col_s1_ff <= column_sense_inputs;
         col_s2_ff <= col_s1_ff;
         pin_s1_ff <= {lockout_select, mode_select_high, mode_select_low};
         pin_s2_ff <= pin_s1_ff;
      end
   end
   assign lo_sel   = pin_s2_ff[2];
   assign mode_idx = pin_s2_ff[1:0];

   // ----------------------------------------------------------------
   // position decode
   // ----------------------------------------------------------------
   assign pos     = pos_of(row_ff, col_ff);
   assign sensed  = col_s2_ff[col_ff];
   assign stored  = key_mem_ff[pos];
   // a new closure only counts while free scanning
   assign hit_new = sensed && !stored && (state_ff == KME_SCAN);
   // a set memory bit with no closure flags a key that has gone open
   assign hit_rel = !sensed && stored && (state_ff != KME_HOLD);
   assign det     = ev && hit_new;
   assign rel     = ev && hit_rel;
   assign adv     = ev && (state_ff == KME_SCAN) && !hit_new && !hit_rel;

   // ----------------------------------------------------------------
   // scan counters
   // ----------------------------------------------------------------
   // column mod 10 inside row mod 9: 90 scan cycles per pass
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         row_ff <= 4'h0;
         col_ff <= 4'h0;
      end else if (adv) begin
         if (col_ff == 4'(KME_COLS - 1)) begin
            col_ff <= 4'h0;
            row_ff <= (row_ff == 4'(KME_ROWS - 1)) ? 4'h0 : row_ff + 4'h1;
         end else begin
            col_ff <= col_ff + 4'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // scan control
   // ----------------------------------------------------------------
   // lock is held at the locked position, so its release is found there
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_ff    <= KME_SCAN;
         hold_cnt_ff <= 17'h00000;
         locked_ff   <= 1'b0;
      end else if (det) begin
         state_ff    <= KME_HOLD;
         hold_cnt_ff <= 17'(delay_ff) + KME_DET_EXTRA;
         locked_ff   <= lo_sel;
      end else if (rel) begin
         state_ff    <= KME_HOLD;
         hold_cnt_ff <= (delay_ff == 16'h0000) ? 17'h00001 : 17'(delay_ff);
         locked_ff   <= 1'b0;
      end else if (ev && state_ff == KME_HOLD) begin
         hold_cnt_ff <= hold_cnt_ff - 17'h00001;
         if (hold_cnt_ff == 17'h00001) begin
            state_ff <= locked_ff ? KME_LOCK : KME_SCAN;
         end
      end
   end
   assign delay_node = (state_ff == KME_HOLD);

   // ----------------------------------------------------------------
   // key position memory
   // ----------------------------------------------------------------
   // one bit per position keeps roll-over from finding a held key twice
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         for (int i = 0; i < KME_KEYS; i++) begin
            key_mem_ff[i] <= 1'b0;
         end
      end else if (det) begin
         key_mem_ff[pos] <= 1'b1;
      end else if (rel) begin
         key_mem_ff[pos] <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // output word and data ready
   // ----------------------------------------------------------------
   // word changes only on a detection, which covers both handling modes
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         word_ff <= 10'h000;
      end else if (det) begin
         word_ff <= rom_code(mode_idx, pos);
      end
   end
   assign encoded_word_outputs = word_ff;

   // pending one half, then high for two halves
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         dr_left_ff <= 2'h0;
         dr_ff      <= 1'b0;
      end else if (det) begin
         dr_left_ff <= 2'h3;
      end else if (tick) begin
         dr_ff <= (dr_left_ff >= 2'h2);
         if (dr_left_ff != 2'h0) begin
            dr_left_ff <= dr_left_ff - 2'h1;
         end
      end
   end
   assign data_ready = dr_ff;

   // ----------------------------------------------------------------
   // matrix drive
   // ----------------------------------------------------------------
   // rows driven in evaluate only; precharge flag mirrors the other half
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         row_drv_ff <= 9'h000;
         pre_ff     <= 1'b1;
      end else if (tick) begin
         pre_ff <= phase_ff;
         if (!phase_ff && state_ff != KME_HOLD) begin
            row_drv_ff <= 9'h001 << row_ff;
         end else begin
            row_drv_ff <= 9'h000;
         end
      end
   end
   assign row_drive_outputs = row_drv_ff;
   assign precharge_active  = pre_ff;

   // ----------------------------------------------------------------
   // register port and interrupt
   // ----------------------------------------------------------------
   // a new event beats a write-one clear in the same cycle
   always_comb begin
      nxt_stat = stat_ff;
      if (reg_wr && reg_addr == KME_OFF_STAT) begin
         nxt_stat = stat_ff & ~reg_wdata[KME_EV_W-1:0];
      end
      if (det) begin
         nxt_stat[KME_EV_DET] = 1'b1;
      end
      if (rel) begin
         nxt_stat[KME_EV_REL] = 1'b1;
      end
   end

   // software writes
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         delay_ff <= KME_DELAY_RST;
         mask_ff  <= KME_MASK_RST;
         stat_ff  <= 2'h0;
      end else begin
         stat_ff <= nxt_stat;
         if (reg_wr && reg_addr == KME_OFF_CTRL) begin
            delay_ff <= reg_wdata[15:0];
         end
         if (reg_wr && reg_addr == KME_OFF_MASK) begin
            mask_ff <= reg_wdata[KME_EV_W-1:0];
         end
      end
   end

   // read data stands the cycle after the strobe only
   always_ff @(posedge ref_clk) begin
      if (rst || !reg_rd) begin
         rdata_ff <= 32'h00000000;
      end else begin
         unique case (reg_addr)
            KME_OFF_CTRL: rdata_ff <= {16'h0000, delay_ff};
            KME_OFF_STAT: rdata_ff <= {30'h00000000, stat_ff};
            KME_OFF_MASK: rdata_ff <= {30'h00000000, mask_ff};
            KME_OFF_WORD: begin
               rdata_ff <= 32'h00000000;
               rdata_ff[9:0] <= word_ff;
               rdata_ff[KME_WD_POS +: 7] <= pos;
               rdata_ff[KME_WD_LOCK] <= locked_ff;
            end
            default:      rdata_ff <= 32'h00000000;
         endcase
      end
   end
   assign reg_rdata = rdata_ff;
   assign irq       = |(stat_ff & mask_ff);

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   // length of the current data ready pulse, in ref_clk cycles
   logic [31:0] dr_len_ff;
   always_ff @(posedge ref_clk) begin
      if (rst || !dr_ff) begin
         dr_len_ff <= 32'h00000000;
      end else begin
         dr_len_ff <= dr_len_ff + 32'h00000001;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   sequence s_detect;
      ev && hit_new;
   endsequence
   sequence s_release;
      ev && hit_rel;
   endsequence
   sequence s_hold_end;
      ev && state_ff == KME_HOLD && hold_cnt_ff == 17'h00001;
   endsequence

   dr_length_a: assert property ($fell(dr_ff) |-> $past(dr_len_ff) == 32'(2*HALF_CYC - 1))
      else $error("data ready width wrong");
   dr_quiet_a: assert property (s_detect |=> !dr_ff [*1] ##0 dr_left_ff == 2'h3)
      else $error("data ready not pending after detect");
   word_load_a: assert property (
      s_detect |=> word_ff == rom_code($past(mode_idx), $past(pos)))
      else $error("word not loaded on detect");
   scan_halt_a: assert property (s_detect |=> state_ff == KME_HOLD && $stable(pos))
      else $error("scan did not halt");
   key_store_a: assert property (s_detect |=> key_mem_ff[$past(pos)])
      else $error("position not stored");
   hold_len_a: assert property (
      s_detect |=> hold_cnt_ff == 17'($past(delay_ff)) + 17'h00002)
      else $error("hold length wrong");
   release_hold_a: assert property (s_release |=> state_ff == KME_HOLD && !locked_ff)
      else $error("release did not halt");
   resume_a: assert property (s_hold_end |=> state_ff != KME_HOLD)
      else $error("scan did not resume");
   pos_range_a: assert property (row_ff < 4'h9 && col_ff < 4'ha)
      else $error("counter out of range");
   wrap_a: assert property (adv && pos == 7'h59 |=> pos == 7'h00)
      else $error("scan did not wrap at 90");
   row_onehot_a: assert property ($onehot0(row_drv_ff) && !(pre_ff && |row_drv_ff))
      else $error("row drive during precharge");
   lock_word_a: assert property (state_ff == KME_LOCK |=> $stable(word_ff))
      else $error("word changed under lock");
   lock_mode_a: assert property (s_detect ##0 lo_sel |=> locked_ff)
      else $error("lockout not taken");
   irq_det_a: assert property (s_detect ##0 mask_ff[KME_EV_DET] |=> irq)
      else $error("interrupt missing");

endmodule

// ### verification/kme_key_matrix.sv
// key switch matrix model: a held key ties its row drive onto its column
// assumes rows are high only in evaluate and open columns read low
`timescale 1ns/100ps

module kme_key_matrix (
   // row drive from the encoder
   input  wire logic [kme_pkg::KME_ROWS-1:0] row_drive_outputs,
   // held keys from the bench, bit row*10+col
   input  wire logic [kme_pkg::KME_KEYS-1:0] key_down,
   // column sense back to the encoder
   output logic      [kme_pkg::KME_COLS-1:0] column_sense_inputs
);
   import kme_pkg::*;

   // ----------------------------------------------------------------
   // switch contacts
   // ----------------------------------------------------------------
   // undriven rows give low columns, so a stale closure never lingers
   always_comb begin
      column_sense_inputs = '0;
      for (int r = 0; r < KME_ROWS; r++) begin
         for (int c = 0; c < KME_COLS; c++) begin
            if (row_drive_outputs[r] && key_down[r*KME_COLS+c]) begin
               column_sense_inputs[c] = 1'b1;
            end
         end
      end
   end

endmodule

// ### verification/testbench.sv
// self-checking bench of the keyboard matrix encoder
// assumes a shortened half scan cycle of 4 clocks and the key matrix model
`timescale 1ns/100ps

`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin mismatches++; \
   $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end

module testbench;
   import kme_pkg::*;

   localparam int HALF = 4;
   localparam int SCAN = KME_KEYS * 2 * HALF;

   typedef struct {
      logic [1:0] mode;
      logic       lock;
      int         pos;
      int         dly;
      logic [9:0] word;
   } kme_row_s;

   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic [9:0]  column_sense_inputs;
   logic [8:0]  row_drive_outputs;
   logic        precharge_active;
   logic        delay_node;
   logic        data_ready;
   logic        irq;
   logic        lockout_select = 1'b0;
   logic        mode_select_low = 1'b0;
   logic        mode_select_high = 1'b0;
   logic [9:0]  encoded_word_outputs;
   logic [3:0]  reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic [89:0] key_down = '0;
   int          mismatches = 0;
   int          comparisons = 0;

   // mode, lockout, key position, delay, expected word
   kme_row_s rows [4] = '{'{2'h0, 1'b0, 0, 8, 10'h000}, '{2'h1, 1'b1, 89, 3, 10'h159},
                          '{2'h2, 1'b0, 45, 0, 10'h22d}, '{2'h3, 1'b1, 17, 1, 10'h311}};

   // ----------------------------------------------------------------
   // clock, design and far side
   // ----------------------------------------------------------------
   always #2.5 ref_clk = ~ref_clk;

   kme_encoder #(.HALF_CYC(HALF), .DELAY_W(16)) i_kme_encoder (
      .ref_clk(ref_clk), .rst(rst), .column_sense_inputs(column_sense_inputs),
      .row_drive_outputs(row_drive_outputs), .precharge_active(precharge_active),
      .delay_node(delay_node), .lockout_select(lockout_select),
      .mode_select_low(mode_select_low), .mode_select_high(mode_select_high),
      .encoded_word_outputs(encoded_word_outputs), .data_ready(data_ready),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .irq(irq));

   kme_key_matrix i_kme_key_matrix (
      .row_drive_outputs(row_drive_outputs), .key_down(key_down),
      .column_sense_inputs(column_sense_inputs));

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   // one halt: samples at edges only, so no cycle is counted twice
   task automatic catch_key(output int dn, output int dr, output int fi, output logic [9:0] w);
      int n;
      n = 0;
      dn = 0;
      dr = 0;
      fi = -1;
      w = 'x;
      @(posedge ref_clk);
      while (delay_node !== 1'b1 && n < SCAN + 100) begin
         @(posedge ref_clk);
         n++;
      end
      while (delay_node === 1'b1 && dn < 400) begin
         if (data_ready === 1'b1) begin
            dr++;
            if (fi < 0) fi = dn;
            w = encoded_word_outputs;
         end
         dn++;
         @(posedge ref_clk);
      end
   endtask

   function automatic logic [9:0] kw(input int p);
      return {2'h3, 1'b0, 7'(p)};
   endfunction

   task automatic finish_test();
      if (mismatches == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // checks and sequence
   // ----------------------------------------------------------------
   // a row is driven only alone and never while precharging
   always @(posedge ref_clk) begin
      if (rst === 1'b0 && row_drive_outputs !== 9'h000) begin
         `CHK({$onehot(row_drive_outputs), precharge_active}, 2'b10)
      end
   end

   // watchdog sized well above the whole sequence
   initial begin
      repeat (60000) @(posedge ref_clk);
      mismatches++;
      finish_test();
   end

   initial begin
      logic [31:0] d;
      int          dn;
      int          dr;
      int          fi;
      int          n;
      logic [9:0]  w;
      logic [9:0]  w2;
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      #1;
      `CHK({row_drive_outputs, data_ready, delay_node, irq}, 12'h000)
      `CHK(encoded_word_outputs, 10'h000)
      n = 0;
      while (row_drive_outputs === 9'h000 && n < 100) begin
         @(posedge ref_clk);
         n++;
      end
      `CHK(row_drive_outputs, 9'h001)
      reg_read(KME_OFF_CTRL, d);
      `CHK(d, 32'h00000008)
      reg_read(KME_OFF_MASK, d);
      `CHK(d, 32'h00000000)
      reg_read(KME_OFF_STAT, d);
      `CHK(d, 32'h00000000)
      reg_read(4'h2, d);
      `CHK(d, 32'h00000000)
      // every code mode and both handlings, detection then release
      for (int i = 0; i < 4; i++) begin
         reg_write(KME_OFF_CTRL, 32'(rows[i].dly));
         {mode_select_high, mode_select_low} <= rows[i].mode;
         lockout_select <= rows[i].lock;
         repeat (4) @(posedge ref_clk);
         key_down[rows[i].pos] <= 1'b1;
         catch_key(dn, dr, fi, w);
         `CHK(dn, (rows[i].dly + 2) * 2 * HALF)
         `CHK(dr, 2 * HALF)
         `CHK(fi, HALF)
         `CHK(w, rows[i].word)
         `CHK(irq, 1'b0)
         reg_read(KME_OFF_WORD, d);
         `CHK(d & 32'h010003ff, {7'h0, rows[i].lock, 14'h0, rows[i].word})
         reg_read(KME_OFF_STAT, d);
         `CHK(d, 32'h00000001)
         reg_write(KME_OFF_STAT, 32'h3);
         key_down[rows[i].pos] <= 1'b0;
         catch_key(dn, dr, fi, w2);
         `CHK(dn, ((rows[i].dly == 0) ? 1 : rows[i].dly) * 2 * HALF)
         `CHK(dr, 0)
         `CHK(encoded_word_outputs, rows[i].word)
         reg_read(KME_OFF_STAT, d);
         `CHK(d, 32'h00000002)
         reg_write(KME_OFF_STAT, 32'h3);
      end
      // interrupt raised, cleared and masked
      reg_write(KME_OFF_MASK, 32'h3);
      lockout_select <= 1'b0;
      key_down[5] <= 1'b1;
      catch_key(dn, dr, fi, w);
      `CHK(irq, 1'b1)
      reg_write(KME_OFF_STAT, 32'h1);
      repeat (2) @(posedge ref_clk);
      `CHK(irq, 1'b0)
      reg_write(KME_OFF_WORD, 32'hffffffff);
      reg_read(KME_OFF_WORD, d);
      `CHK(d[9:0], kw(5))
      key_down[5] <= 1'b0;
      catch_key(dn, dr, fi, w);
      `CHK(irq, 1'b1)
      reg_write(KME_OFF_MASK, 32'h0);
      repeat (2) @(posedge ref_clk);
      `CHK(irq, 1'b0)
      reg_write(KME_OFF_STAT, 32'h3);
      // lockout: a second key stays unseen until the first is released
      lockout_select <= 1'b1;
      key_down[12] <= 1'b1;
      catch_key(dn, dr, fi, w);
      `CHK(w, kw(12))
      key_down[34] <= 1'b1;
      n = 0;
      repeat (3 * SCAN) begin
         @(posedge ref_clk);
         if (data_ready === 1'b1) n++;
      end
      `CHK(n, 0)
      `CHK(encoded_word_outputs, kw(12))
      key_down[12] <= 1'b0;
      catch_key(dn, dr, fi, w);
      `CHK(dr, 0)
      catch_key(dn, dr, fi, w);
      `CHK(w, kw(34))
      key_down[34] <= 1'b0;
      catch_key(dn, dr, fi, w);
      // roll-over: two keys held together both come out
      lockout_select <= 1'b0;
      key_down[20] <= 1'b1;
      key_down[70] <= 1'b1;
      catch_key(dn, dr, fi, w);
      catch_key(dn, dr, fi, w2);
      `CHK((w === kw(20) && w2 === kw(70)) || (w === kw(70) && w2 === kw(20)), 1'b1)
      key_down[20] <= 1'b0;
      key_down[70] <= 1'b0;
      catch_key(dn, dr, fi, w);
      `CHK(dr, 0)
      catch_key(dn, dr, fi, w);
      `CHK(dr, 0)
      // reset mid-run: memory cleared, so a key still held is found again
      key_down[40] <= 1'b1;
      catch_key(dn, dr, fi, w);
      `CHK(w, kw(40))
      rst <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      `CHK({encoded_word_outputs, data_ready, delay_node, precharge_active}, 13'h001)
      catch_key(dn, dr, fi, w);
      `CHK(w, kw(40))
      `CHK(dn, (int'(KME_DELAY_RST) + 2) * 2 * HALF)
      key_down[40] <= 1'b0;
      finish_test();
   end

endmodule
